// File: dac_i2c_pkg.sv
package dac_i2c_pkg;

    // Fixed upper address bits
    localparam logic [4:0] ADDR_FIXED      = 5'h15;
    // Pointer value that requests burst mode
    localparam logic [7:0] PTR_BURST       = 8'hff;
    // Bit count of one byte
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    // Field positions
    localparam int         ADDR_RW_BIT     = 0;
    localparam int         PTR_CH_MSB      = 5;
    localparam int         DATA_SEL_HI_BIT = 7;
    localparam int         DATA_SEL_LO_BIT = 6;
    // Bus timing
    localparam int         CLK_HZ          = 40_000_000;
    localparam int         SCL_MAX_HZ      = 400_000;
    localparam int         SCL_MIN_CYCLES  = CLK_HZ / SCL_MAX_HZ;

    // Byte phase within a transaction
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_ADDR    = 3'b001,
        PH_PTR     = 3'b010,
        PH_DATA_HI = 3'b011,
        PH_DATA_LO = 3'b100,
        PH_IGNORE  = 3'b101
    } phase_t;

    // One completed channel update
    typedef struct packed {
        logic [5:0] channel_number;
        logic       dest_sel_hi;
        logic       dest_sel_lo;
        logic [13:0] data;
    } update_t;

    // Conditions seen on the bus lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } line_ev_t;

endpackage : dac_i2c_pkg

// File: line_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for both bus lines plus condition detection
module line_sync (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output dac_i2c_pkg::line_ev_t     ev
);
    logic [1:0] scl_meta_reg, scl_meta_next;
    logic [1:0] sda_meta_reg, sda_meta_next;
    logic       scl_reg, scl_next;
    logic       sda_reg, sda_next;

    // Shift chain: meta stage, sync stage, history stage
    always_comb begin
        scl_meta_next = {scl_meta_reg[0], scl_in};
        sda_meta_next = {sda_meta_reg[0], sda_in};
        scl_next      = scl_meta_reg[1];
        sda_next      = sda_meta_reg[1];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_meta_reg <= 2'h3;
            sda_meta_reg <= 2'h3;
            scl_reg      <= 1'b1;
            sda_reg      <= 1'b1;
        end else begin
            scl_meta_reg <= scl_meta_next;
            sda_meta_reg <= sda_meta_next;
            scl_reg      <= scl_next;
            sda_reg      <= sda_next;
        end
    end

    // Edges compare sync stage against history stage
    always_comb begin
        ev.sda      = sda_meta_reg[1];
        ev.scl_rise = scl_meta_reg[1] & ~scl_reg;
        ev.scl_fall = ~scl_meta_reg[1] & scl_reg;
        ev.start    = scl_meta_reg[1] & scl_reg & sda_reg & ~sda_meta_reg[1]; // [RULE2]
        ev.stop     = scl_meta_reg[1] & scl_reg & ~sda_reg & sda_meta_reg[1]; // [RULE3]
    end

endmodule : line_sync

// File: dac_i2c_write_receiver.sv
`timescale 1ns/100ps
// Operation
// [RULE1] One bit per SCL cycle, sampled while SCL is high.
// [RULE2] SDA falling with SCL high is START; restart at address byte.
// [RULE3] SDA rising with SCL high is STOP; return to idle.
// [RULE4] Repeated START is handled as a fresh START.
// [RULE5] Acknowledge each accepted byte by holding SDA low for ninth clock.
// [RULE6] Master checks acknowledges and retries when one is missing.
// [RULE7] Idle waits for START then 7-bit address plus direction bit.
// [RULE8] Address must be 10101 followed by the two select pins.
// [RULE9] Receive only; read requests are not acknowledged.
// [RULE10] Address, pointer, two data bytes, STOP; each byte acknowledged.
// [RULE11] Update applied only after both data bytes acknowledged.
// [RULE12] Without STOP, next byte is a new pointer.
// [RULE13] Two select bits in high data byte choose destination register.
// [RULE14] STOP anywhere discards partial update and goes idle.
// [RULE15] Pointer 0xFF flags burst mode request, not a channel; the code still loads channel 63 from it and takes both data bytes as an update.
// [RULE16] Works with SCL up to 400 kHz.
// [RULE17] Pointer is 00 plus channel; high data byte starts with select bits.
// [RULE18] SDA driven only low; SCL never driven.
module dac_i2c_write_receiver (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    input  wire logic                 addr_sel_hi_pin,
    input  wire logic                 addr_sel_lo_pin,
    output dac_i2c_pkg::update_t      update,
    output logic                      update_valid,
    output logic                      burst_request
);
    dac_i2c_pkg::line_ev_t ev;
    dac_i2c_pkg::phase_t   phase_reg, phase_next;
    logic [7:0]  shift_reg, shift_next;
    logic [3:0]  count_reg, count_next;
    logic        ack_reg, ack_next;
    logic        ack_pend_reg, ack_pend_next;
    logic [1:0]  sel_pins_reg, sel_pins_meta_reg;
    logic [5:0]  chan_reg, chan_next;
    logic [7:0]  hi_reg, hi_next;
    dac_i2c_pkg::update_t upd_reg, upd_next;
    logic        upd_valid_reg, upd_valid_next;
    logic        burst_reg, burst_next;
    logic        byte_done;
    logic        accept;
    logic        upd_commit_reg, upd_commit_next;

    // Line sampling leaves about 100 clocks per bit at the fastest bus rate
    line_sync u_line_sync (                                                   // [RULE16]
        .clk     (clk),
        .reset_n (reset_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev      (ev)
    );

    // Select pins come from outside, so sync them too
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_pins_meta_reg <= 2'h0;
            sel_pins_reg      <= 2'h0;
        end else begin
            sel_pins_meta_reg <= {addr_sel_hi_pin, addr_sel_lo_pin};
            sel_pins_reg      <= sel_pins_meta_reg;
        end
    end

    // A byte completes on the eighth rising edge of SCL
    assign byte_done = ev.scl_rise && !ack_reg
                       && (count_reg == dac_i2c_pkg::BITS_PER_BYTE - 4'h1);

    // Decide whether the byte now completing earns an acknowledge
    always_comb begin
        logic [7:0] b;
        b = {shift_reg[6:0], ev.sda};
        unique case (phase_reg)
            dac_i2c_pkg::PH_ADDR:
                accept = (b[7:3] == dac_i2c_pkg::ADDR_FIXED)                 // [RULE8]
                         && (b[2:1] == sel_pins_reg)                          // [RULE8]
                         && !b[dac_i2c_pkg::ADDR_RW_BIT];                     // [RULE9]
            dac_i2c_pkg::PH_PTR,
            dac_i2c_pkg::PH_DATA_HI,
            dac_i2c_pkg::PH_DATA_LO:
                accept = 1'b1;                                                // [RULE10]
            default:
                accept = 1'b0;
        endcase
    end

    // Byte receiver and transaction sequencer
    always_comb begin
        logic [7:0] b;
        b              = {shift_reg[6:0], ev.sda};
        phase_next     = phase_reg;
        shift_next     = shift_reg;
        count_next     = count_reg;
        ack_next       = ack_reg;
        ack_pend_next  = ack_pend_reg;
        chan_next      = chan_reg;
        hi_next        = hi_reg;
        upd_next       = upd_reg;
        upd_valid_next = 1'b0;
        burst_next     = 1'b0;
        if (ev.stop) begin
            phase_next    = dac_i2c_pkg::PH_IDLE;                             // [RULE14]
            ack_next      = 1'b0;
            ack_pend_next = 1'b0;
            count_next    = 4'h0;
        end else if (ev.start) begin
            phase_next    = dac_i2c_pkg::PH_ADDR;                             // [RULE4]
            ack_next      = 1'b0;
            ack_pend_next = 1'b0;
            count_next    = 4'h0;
        end else if (phase_reg != dac_i2c_pkg::PH_IDLE) begin                 // [RULE7]
            if (ev.scl_rise && !ack_reg) begin
                shift_next = b;                                               // [RULE1]
                count_next = count_reg + 4'h1;
            end
            if (byte_done) begin
                count_next    = 4'h0;
                ack_pend_next = accept;
                unique case (phase_reg)
                    dac_i2c_pkg::PH_ADDR:
                        phase_next = accept ? dac_i2c_pkg::PH_PTR
                                            : dac_i2c_pkg::PH_IGNORE;
                    dac_i2c_pkg::PH_PTR: begin
                        chan_next  = b[dac_i2c_pkg::PTR_CH_MSB:0];            // [RULE17]
                        burst_next = (b == dac_i2c_pkg::PTR_BURST);           // [RULE15]
                        phase_next = dac_i2c_pkg::PH_DATA_HI;
                    end
                    dac_i2c_pkg::PH_DATA_HI: begin
                        hi_next    = b;
                        phase_next = dac_i2c_pkg::PH_DATA_LO;
                    end
                    dac_i2c_pkg::PH_DATA_LO: begin
                        upd_next.channel_number = chan_reg;
                        upd_next.dest_sel_hi    = hi_reg[dac_i2c_pkg::DATA_SEL_HI_BIT]; // [RULE13]
                        upd_next.dest_sel_lo    = hi_reg[dac_i2c_pkg::DATA_SEL_LO_BIT]; // [RULE13]
                        upd_next.data           = {hi_reg[5:0], b};
                        phase_next              = dac_i2c_pkg::PH_PTR;        // [RULE12]
                    end
                    default: ;
                endcase
            end
            // Drive acknowledge from the falling edge after bit 8 to the next one
            if (ev.scl_fall && ack_pend_reg) begin
                ack_next      = 1'b1;                                         // [RULE5]
                ack_pend_next = 1'b0;
            end else if (ev.scl_fall && ack_reg) begin
                ack_next = 1'b0;
                // The update commits when its last acknowledge completes
                upd_valid_next = (phase_reg == dac_i2c_pkg::PH_PTR)
                                 && (count_reg == 4'h0) && upd_commit_reg;    // [RULE11]
            end
        end
    end

    // Marks that the acknowledged byte closed a data pair
    always_comb begin
        upd_commit_next = upd_commit_reg;
        if (ev.stop || ev.start)
            upd_commit_next = 1'b0;                                           // [RULE14]
        else if (byte_done)
            upd_commit_next = (phase_reg == dac_i2c_pkg::PH_DATA_LO);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_reg      <= dac_i2c_pkg::PH_IDLE;
            shift_reg      <= 8'h00;
            count_reg      <= 4'h0;
            ack_reg        <= 1'b0;
            ack_pend_reg   <= 1'b0;
            chan_reg       <= 6'h00;
            hi_reg         <= 8'h00;
            upd_reg        <= '0;
            upd_valid_reg  <= 1'b0;
            burst_reg      <= 1'b0;
            upd_commit_reg <= 1'b0;
        end else begin
            phase_reg      <= phase_next;
            shift_reg      <= shift_next;
            count_reg      <= count_next;
            ack_reg        <= ack_next;
            ack_pend_reg   <= ack_pend_next;
            chan_reg       <= chan_next;
            hi_reg         <= hi_next;
            upd_reg        <= upd_next;
            upd_valid_reg  <= upd_valid_next;
            burst_reg      <= burst_next;
            upd_commit_reg <= upd_commit_next;
        end
    end

    // Open-drain: only ever pull low, enable active low
    assign sda_out       = 1'b0;                                              // [RULE18]
    assign sda_oe_n      = ~ack_reg;                                          // [RULE18]
    assign update        = upd_reg;
    assign update_valid  = upd_valid_reg;
    assign burst_request = burst_reg;

    // Acknowledge released exactly at the next SCL fall
    a_ack_release: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
        ack_reg && ev.scl_fall && !ev.stop && !ev.start |=> !ack_reg)
        else $error("acknowledge not released");

    // No acknowledge ever starts while idle
    a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
        $rose(ack_reg) |-> $past(phase_reg) != dac_i2c_pkg::PH_IDLE)
        else $error("acknowledge while idle");

    // STOP returns to idle next cycle
    a_stop_idle: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
        ev.stop |=> phase_reg == dac_i2c_pkg::PH_IDLE && !ack_reg)
        else $error("stop did not reach idle");

    // START restarts at address byte
    a_start_addr: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
        ev.start && !ev.stop |=> phase_reg == dac_i2c_pkg::PH_ADDR && count_reg == 4'h0)
        else $error("start did not restart address");

    // A read request never earns an acknowledge
    a_no_read_ack: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
        byte_done && phase_reg == dac_i2c_pkg::PH_ADDR && ev.sda |=> !ack_pend_reg)
        else $error("read request acknowledged");

    // Updates pulse only one cycle and only in pointer phase
    a_update_pulse: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
        update_valid |-> phase_reg == dac_i2c_pkg::PH_PTR ##1 !update_valid)
        else $error("bad update pulse");

    // SDA is only ever pulled low, and only inside an addressed transfer
    a_sda_low: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
        !sda_oe_n |-> sda_out == 1'b0 && phase_reg != dac_i2c_pkg::PH_IDLE
                      && phase_reg != dac_i2c_pkg::PH_IGNORE)
        else $error("sda driven outside an acknowledge");

    // Burst flag follows pointer completion by one cycle
    a_burst_flag: assert property (@(posedge clk) disable iff (!reset_n) // [RULE15]
        burst_request |-> $past(phase_reg) == dac_i2c_pkg::PH_PTR
                          && phase_reg == dac_i2c_pkg::PH_DATA_HI)
        else $error("burst flag out of place");

endmodule : dac_i2c_write_receiver

// File: i2c_master_model.sv
`timescale 1ns/100ps
// Bus master stand-in: drives SCL and pulls SDA; pull-ups keep released lines high
module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda_bus,
    output logic      scl_drv,
    output logic      sda_drv
);
    int half_cyc = 50;

    // Idle bus: both lines released
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // Advance n clocks, landing just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // START from idle, or repeated START from SCL low
    task automatic start_cond();
        sda_drv = 1'b1;
        tick(half_cyc / 2);
        scl_drv = 1'b1;
        tick(half_cyc / 2);
        sda_drv = 1'b0;
        tick(half_cyc / 2);
        scl_drv = 1'b0;
        tick(half_cyc / 2);
    endtask : start_cond

    // STOP: SDA rises while SCL is high
    task automatic stop_cond();
        sda_drv = 1'b0;
        tick(half_cyc / 2);
        scl_drv = 1'b1;
        tick(half_cyc / 2);
        sda_drv = 1'b1;
        tick(half_cyc);
    endtask : stop_cond

    // One byte MSB first, then the ninth clock; ack only if low just after SCL rises and just before it falls
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic early;
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            tick(half_cyc / 2);
            scl_drv = 1'b1;
            tick(half_cyc);
            scl_drv = 1'b0;
            tick(half_cyc / 2);
        end
        sda_drv = 1'b1;
        tick(half_cyc / 2);
        scl_drv = 1'b1;
        tick(1);
        early = ~sda_bus;
        tick(half_cyc - 2);
        ack = early & ~sda_bus;
        tick(1);
        scl_drv = 1'b0;
        tick(half_cyc / 2);
    endtask : send_byte
endmodule : i2c_master_model

// File: dac_i2c_write_receiver_bench.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module dac_i2c_write_receiver_bench;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 addr_sel_hi_pin = 1'b0;
    logic                 addr_sel_lo_pin = 1'b0;
    logic                 scl_drv;
    logic                 sda_drv;
    logic                 sda_out;
    logic                 sda_oe_n;
    logic                 sda_bus;
    logic                 update_valid;
    logic                 burst_request;
    logic                 ack;
    dac_i2c_pkg::update_t update;
    dac_i2c_pkg::update_t last_upd;
    int                   upd_cnt;
    int                   burst_cnt;
    int                   mismatches;
    int                   cmp_count;

    always #12.5 clk = ~clk;

    // Open-drain data line with pull-up
    assign sda_bus = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

    dac_i2c_write_receiver uut (
        .clk(clk), .reset_n(reset_n), .scl_in(scl_drv), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_hi_pin(addr_sel_hi_pin),
        .addr_sel_lo_pin(addr_sel_lo_pin), .update(update), .update_valid(update_valid),
        .burst_request(burst_request));

    i2c_master_model master (.clk(clk), .sda_bus(sda_bus), .scl_drv(scl_drv), .sda_drv(sda_drv));

    // Record pulses away from the launching edge
    always @(negedge clk) begin
        if (update_valid === 1'b1) begin
            upd_cnt++;
            last_upd = update;
        end
        if (burst_request === 1'b1) begin
            burst_cnt++;
        end
    end

    function automatic dac_i2c_pkg::update_t exp_upd(input logic [7:0] p, input logic [7:0] h,
                                                     input logic [7:0] l);
        return {p[5:0], h[7], h[6], h[5:0], l};
    endfunction : exp_upd

    task automatic put(input logic [7:0] b, input logic exp_ack);
        master.send_byte(b, ack);
        `CHECK(ack, exp_ack)
    endtask : put

    // Pointer and two data bytes; update only after the low byte
    task automatic triplet(input logic [7:0] p, input logic [7:0] h, input logic [7:0] l);
        int n;
        n = upd_cnt;
        put(p, 1'b1);
        put(h, 1'b1);
        `CHECK(upd_cnt, n)
        put(l, 1'b1);
        `CHECK(upd_cnt, n + 1)
        `CHECK(last_upd, exp_upd(p, h, l))
    endtask : triplet

    task automatic t_single();
        logic [1:0] s;
        for (int k = 0; k < 4; k++) begin
            s = k[1:0];
            {addr_sel_hi_pin, addr_sel_lo_pin} = s;
            master.start_cond();
            put({dac_i2c_pkg::ADDR_FIXED, s, 1'b0}, 1'b1);
            triplet({6'h08, s}, {s, 6'h2a}, {s, 6'h15});
            master.stop_cond();
            `CHECK(sda_oe_n, 1'b1)
        end
        $display("test single done");
    endtask : t_single

    task automatic t_refuse();
        upd_cnt = 0;
        {addr_sel_hi_pin, addr_sel_lo_pin} = 2'b10;
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b01, 1'b0}, 1'b0);
        put(8'h01, 1'b0);
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b10, 1'b1}, 1'b0);
        put(8'h01, 1'b0);
        master.start_cond();
        put({5'h14, 2'b10, 1'b0}, 1'b0);
        master.stop_cond();
        `CHECK(upd_cnt, 0)
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_multi();
        upd_cnt = 0;
        burst_cnt = 0;
        master.half_cyc = 64;
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b10, 1'b0}, 1'b1);
        triplet(8'h00, 8'h40, 8'h01);
        triplet(dac_i2c_pkg::PTR_BURST, 8'hbf, 8'hfe);
        `CHECK(burst_cnt, 1)
        triplet(8'h27, 8'h80, 8'h55);
        master.stop_cond();
        `CHECK(upd_cnt, 3)
        master.half_cyc = 50;
        $display("test multi done");
    endtask : t_multi

    task automatic t_abort();
        upd_cnt = 0;
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b10, 1'b0}, 1'b1);
        put(8'h03, 1'b1);
        put(8'h11, 1'b1);
        master.stop_cond();
        `CHECK(upd_cnt, 0)
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b10, 1'b0}, 1'b1);
        put(8'h05, 1'b1);
        master.start_cond();
        put({dac_i2c_pkg::ADDR_FIXED, 2'b10, 1'b0}, 1'b1);
        triplet(8'h09, 8'hc7, 8'h3c);
        master.stop_cond();
        `CHECK(upd_cnt, 1)
        $display("test abort done");
    endtask : t_abort

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Run limit
    initial begin
        repeat (95000) @(posedge clk);
        mismatches++;
        $display("Error at %0t: run limit reached", $time);
        close_out();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        master.tick(4);
        `CHECK(sda_oe_n, 1'b1)
        `CHECK(update_valid, 1'b0)
        t_single();
        t_refuse();
        t_multi();
        t_abort();
        close_out();
    end
endmodule : dac_i2c_write_receiver_bench
